// file: logic/psr_unit.sv
// packed simd, move-top and reverse datapath slice with one result register stage
//
// Function
// - move-top puts the immediate in bits 31..16, keeps bits 15..0 of destination
// - move-top leaves all condition flags unchanged
// - word byte-reverse swaps all four bytes of the operand
// - halfword byte-reverse swaps bytes inside each halfword, halves stay put
// - signed-half reverse swaps bottom halfword bytes then sign-extends to 32 bits
// - bit-reverse mirrors all 32 bits of the operand
// - reverse, packed add/sub and halving operations never touch condition flags
// - signed halfword add sums each halfword lane independently
// - signed byte add sums each of four byte lanes independently
// - halving halfword add sums halfword lanes then halves each sum
// - halving byte add sums byte lanes then halves each sum
// - add-sub-exchange: top=(a.top+b.bot)/2, bottom=(a.bot-b.top)/2
// - sub-add-exchange: top=(a.top-b.bot)/2, bottom=(a.bot+b.top)/2
// - halving halfword subtract takes differences per halfword then halves them
// - halving byte subtract takes differences per byte then halves them
// - signed halfword subtract takes two independent halfword differences
// - signed byte subtract takes four independent byte differences
// - omitted destination on packed and halving ops means result goes to the first operand register
`timescale 1ns/1ps
`include "psr_map.svh"

module psr_unit (
    input  wire logic              REF_CLK,
    input  wire logic              RST_B,
    input  wire psr_pkg::psr_issue_t ISSUE,
    output logic                   WR_EN,
    output logic [`PSR_REG_IDX_W-1:0] WR_IDX,
    output logic [`PSR_WORD_W-1:0] WR_DATA,
    output logic [`PSR_FLAGS_W-1:0] FLAGS_OUT,
    output logic                   ILLEGAL_REG
);
    import psr_pkg::*;

    localparam int HW = `PSR_HALF_W;
    localparam int BW = `PSR_BYTE_W;
    localparam int NB = `PSR_WORD_W / `PSR_BYTE_W;
    localparam int NH = `PSR_WORD_W / `PSR_HALF_W;

    logic [`PSR_WORD_W-1:0] a;
    logic [`PSR_WORD_W-1:0] b;
    assign a = ISSUE.first_operand;
    assign b = ISSUE.second_operand;

    // ==========================================================
    // byte lanes: each lane is its own adder, so carries never cross lanes
    logic [`PSR_WORD_W-1:0] add_b;
    logic [`PSR_WORD_W-1:0] sub_b;
    logic [`PSR_WORD_W-1:0] hadd_b;
    logic [`PSR_WORD_W-1:0] hsub_b;
    logic [`PSR_WORD_W-1:0] brev_w;

    genvar gi;
    generate
        for (gi = 0; gi < NB; gi++) begin : g_byte
            logic signed [BW:0] xs;
            logic signed [BW:0] ys;
            logic signed [BW:0] s;
            logic signed [BW:0] d;
            assign xs = {a[gi*BW+BW-1], a[gi*BW +: BW]};
            assign ys = {b[gi*BW+BW-1], b[gi*BW +: BW]};
            assign s  = xs + ys;
            assign d  = xs - ys;
            assign add_b[gi*BW +: BW]  = s[BW-1:0];
            assign sub_b[gi*BW +: BW]  = d[BW-1:0];
            assign hadd_b[gi*BW +: BW] = s[BW:1];
            assign hsub_b[gi*BW +: BW] = d[BW:1];
            assign brev_w[gi*BW +: BW] = a[(NB-1-gi)*BW +: BW];
        end
    endgenerate

    // ==========================================================
    // halfword lanes, straight and exchanged
    logic [`PSR_WORD_W-1:0] add_h;
    logic [`PSR_WORD_W-1:0] sub_h;
    logic [`PSR_WORD_W-1:0] hadd_h;
    logic [`PSR_WORD_W-1:0] hsub_h;
    logic [`PSR_WORD_W-1:0] brev_h;

    generate
        for (gi = 0; gi < NH; gi++) begin : g_half
            logic signed [HW:0] xs;
            logic signed [HW:0] ys;
            logic signed [HW:0] s;
            logic signed [HW:0] d;
            assign xs = {a[gi*HW+HW-1], a[gi*HW +: HW]};
            assign ys = {b[gi*HW+HW-1], b[gi*HW +: HW]};
            assign s  = xs + ys;
            assign d  = xs - ys;
            assign add_h[gi*HW +: HW]  = s[HW-1:0];
            assign sub_h[gi*HW +: HW]  = d[HW-1:0];
            assign hadd_h[gi*HW +: HW] = s[HW:1];
            assign hsub_h[gi*HW +: HW] = d[HW:1];
            assign brev_h[gi*HW +: HW] = {a[gi*HW +: BW], a[gi*HW+BW +: BW]};
        end
    endgenerate

    // exchanged halving: first top with second bottom, first bottom with second top
    logic signed [HW:0] a_top;
    logic signed [HW:0] a_bot;
    logic signed [HW:0] b_top;
    logic signed [HW:0] b_bot;
    logic signed [HW:0] x_tp;
    logic signed [HW:0] x_tm;
    logic signed [HW:0] x_bp;
    logic signed [HW:0] x_bm;
    assign a_top = {a[`PSR_WORD_W-1], a[`PSR_WORD_W-1:HW]};
    assign a_bot = {a[HW-1], a[HW-1:0]};
    assign b_top = {b[`PSR_WORD_W-1], b[`PSR_WORD_W-1:HW]};
    assign b_bot = {b[HW-1], b[HW-1:0]};
    assign x_tp  = a_top + b_bot;
    assign x_tm  = a_top - b_bot;
    assign x_bp  = a_bot + b_top;
    assign x_bm  = a_bot - b_top;

    // ==========================================================
    // bit mirror
    logic [`PSR_WORD_W-1:0] bit_rev;
    generate
        for (gi = 0; gi < `PSR_WORD_W; gi++) begin : g_bit
            assign bit_rev[gi] = a[`PSR_WORD_W-1-gi];
        end
    endgenerate

    // ==========================================================
    // result select and write-back steering
    psr_result_t res_d;
    psr_result_t res_q;
    logic        ill_d;
    logic        ill_q;
    logic [`PSR_FLAGS_W-1:0] flags_d;
    logic [`PSR_FLAGS_W-1:0] flags_q;
    logic [`PSR_HALF_W-1:0]  rev_sh;

    assign rev_sh = brev_h[HW-1:0];

    always_comb begin
        res_d.wr_data = `PSR_WORD_RST;
        case (ISSUE.op)
            PSR_OP_MOVE_TOP_IMMEDIATE:
                res_d.wr_data = {ISSUE.immediate_16, ISSUE.dest_prior[HW-1:0]};
            PSR_OP_BYTE_REVERSE_WORD:        res_d.wr_data = brev_w;
            PSR_OP_BYTE_REVERSE_HALVES:      res_d.wr_data = brev_h;
            PSR_OP_BYTE_REVERSE_SIGNED_HALF:
                res_d.wr_data = {{HW{rev_sh[HW-1]}}, rev_sh};
            PSR_OP_BIT_REVERSE_WORD:         res_d.wr_data = bit_rev;
            PSR_OP_SIGNED_ADD_HALVES:        res_d.wr_data = add_h;
            PSR_OP_SIGNED_ADD_BYTES:         res_d.wr_data = add_b;
            PSR_OP_SIGNED_HALVING_ADD_HALVES: res_d.wr_data = hadd_h;
            PSR_OP_SIGNED_HALVING_ADD_BYTES: res_d.wr_data = hadd_b;
            PSR_OP_HALVING_ADD_SUB_EXCHANGE:
                res_d.wr_data = {x_tp[HW:1], x_bm[HW:1]};
            PSR_OP_HALVING_SUB_ADD_EXCHANGE:
                res_d.wr_data = {x_tm[HW:1], x_bp[HW:1]};
            PSR_OP_SIGNED_HALVING_SUB_HALVES: res_d.wr_data = hsub_h;
            PSR_OP_SIGNED_HALVING_SUB_BYTES: res_d.wr_data = hsub_b;
            PSR_OP_SIGNED_SUB_HALVES:        res_d.wr_data = sub_h;
            PSR_OP_SIGNED_SUB_BYTES:         res_d.wr_data = sub_b;
            default:                         res_d.wr_data = `PSR_WORD_RST;
        endcase
    end

    // destination choice: move-top and reverses always name one; packed ops may omit it
    logic dest_optional;
    always_comb begin
        case (ISSUE.op)
            PSR_OP_MOVE_TOP_IMMEDIATE,
            PSR_OP_BYTE_REVERSE_WORD,
            PSR_OP_BYTE_REVERSE_HALVES,
            PSR_OP_BYTE_REVERSE_SIGNED_HALF,
            PSR_OP_BIT_REVERSE_WORD: dest_optional = 1'b0;
            default:                 dest_optional = 1'b1;
        endcase
    end

    always_comb begin
        res_d.wr_idx = (dest_optional && !ISSUE.dest_given) ? ISSUE.first_idx : ISSUE.dest_idx;
        res_d.wr_en  = ISSUE.valid && ISSUE.cond_pass;
    end

    // the issuer is trusted not to name reserved registers; we only flag it,
    // and still perform the write so behaviour stays defined
    always_comb begin
        ill_d = ISSUE.valid && ((res_d.wr_idx == `PSR_STACK_POINTER_IDX) ||
                                (res_d.wr_idx == `PSR_PROGRAM_COUNTER_IDX) ||
                                (ISSUE.op != PSR_OP_MOVE_TOP_IMMEDIATE &&
                                 ((ISSUE.first_idx == `PSR_STACK_POINTER_IDX) ||
                                  (ISSUE.first_idx == `PSR_PROGRAM_COUNTER_IDX))));
    end

    // flags pass through untouched for every operation of this unit
    always_comb begin
        flags_d = ISSUE.valid ? ISSUE.flags_in : flags_q;
    end

    // ==========================================================
    // single result stage; every output comes from here
    always_ff @(posedge REF_CLK or negedge RST_B) begin
        if (!RST_B) begin
            res_q.wr_en   <= 1'b0;
            res_q.wr_idx  <= `PSR_IDX_RST;
            res_q.wr_data <= `PSR_WORD_RST;
            ill_q         <= 1'b0;
            flags_q       <= `PSR_FLAGS_RST;
        end else begin
            res_q   <= res_d;
            ill_q   <= ill_d;
            flags_q <= flags_d;
        end
    end

    assign WR_EN       = res_q.wr_en;
    assign WR_IDX      = res_q.wr_idx;
    assign WR_DATA     = res_q.wr_data;
    assign FLAGS_OUT   = flags_q;
    assign ILLEGAL_REG = ill_q;

endmodule : psr_unit

// file: logic/psr_map.svh
// register-free constants for the packed simd and reverse unit
`ifndef PSR_MAP_SVH
`define PSR_MAP_SVH

// ==========================================================
// widths
`define PSR_WORD_W      32
`define PSR_HALF_W      16
`define PSR_BYTE_W      8
`define PSR_REG_IDX_W   4
`define PSR_FLAGS_W     4

// ==========================================================
// reserved register indexes the issuer must not name
`define PSR_STACK_POINTER_IDX   4'hD
`define PSR_PROGRAM_COUNTER_IDX 4'hF

// ==========================================================
// reset values
`define PSR_WORD_RST    32'h0000_0000
`define PSR_IDX_RST     4'h0
`define PSR_FLAGS_RST   4'h0

`endif

// file: logic/psr_pkg.sv
// types for the packed simd and reverse unit
`include "psr_map.svh"

package psr_pkg;

    // ==========================================================
    // operation select
    typedef enum logic [3:0] {
        PSR_OP_MOVE_TOP_IMMEDIATE      = 4'h0,
        PSR_OP_BYTE_REVERSE_WORD       = 4'h1,
        PSR_OP_BYTE_REVERSE_HALVES     = 4'h2,
        PSR_OP_BYTE_REVERSE_SIGNED_HALF = 4'h3,
        PSR_OP_BIT_REVERSE_WORD        = 4'h4,
        PSR_OP_SIGNED_ADD_HALVES       = 4'h5,
        PSR_OP_SIGNED_ADD_BYTES        = 4'h6,
        PSR_OP_SIGNED_HALVING_ADD_HALVES = 4'h7,
        PSR_OP_SIGNED_HALVING_ADD_BYTES  = 4'h8,
        PSR_OP_HALVING_ADD_SUB_EXCHANGE  = 4'h9,
        PSR_OP_HALVING_SUB_ADD_EXCHANGE  = 4'hA,
        PSR_OP_SIGNED_HALVING_SUB_HALVES = 4'hB,
        PSR_OP_SIGNED_HALVING_SUB_BYTES  = 4'hC,
        PSR_OP_SIGNED_SUB_HALVES       = 4'hD,
        PSR_OP_SIGNED_SUB_BYTES        = 4'hE
    } psr_op_t;

    // ==========================================================
    // one issued operation
    typedef struct packed {
        logic                          valid;
        psr_op_t                       op;
        logic                          cond_pass;
        logic                          dest_given;
        logic [`PSR_REG_IDX_W-1:0]     dest_idx;
        logic [`PSR_REG_IDX_W-1:0]     first_idx;
        logic [`PSR_WORD_W-1:0]        first_operand;
        logic [`PSR_WORD_W-1:0]        second_operand;
        logic [`PSR_WORD_W-1:0]        dest_prior;
        logic [`PSR_HALF_W-1:0]        immediate_16;
        logic [`PSR_FLAGS_W-1:0]       flags_in;
    } psr_issue_t;

    // ==========================================================
    // one register write back
    typedef struct packed {
        logic                          wr_en;
        logic [`PSR_REG_IDX_W-1:0]     wr_idx;
        logic [`PSR_WORD_W-1:0]        wr_data;
    } psr_result_t;

endpackage : psr_pkg

// file: sim/psr_rf_model.sv
// register file model standing where the core issues operands and takes write backs
`timescale 1ns/1ps
`include "psr_map.svh"

module psr_rf_model (
    input  wire logic                         ref_clk,
    input  wire logic [`PSR_REG_IDX_W-1:0]    a_idx,
    input  wire logic [`PSR_REG_IDX_W-1:0]    b_idx,
    input  wire logic [`PSR_REG_IDX_W-1:0]    p_idx,
    input  wire logic                         wr_en,
    input  wire logic [`PSR_REG_IDX_W-1:0]    wr_idx,
    input  wire logic [`PSR_WORD_W-1:0]       wr_data,
    output logic [`PSR_WORD_W-1:0]            a,
    output logic [`PSR_WORD_W-1:0]            b,
    output logic [`PSR_WORD_W-1:0]            p
);
    logic [`PSR_WORD_W-1:0] rf_q [16];

    // ==========================================================
    // reads have no forwarding, so a result is seen one cycle after its write pulse
    assign a = rf_q[a_idx];
    assign b = rf_q[b_idx];
    assign p = rf_q[p_idx];

    // write back on the pulse only
    always @(posedge ref_clk) begin
        if (wr_en) begin
            rf_q[wr_idx] <= wr_data;
        end
    end

    // preload by the bench between edges
    task load(input logic [3:0] i, input logic [31:0] v);
        rf_q[i] = v;
    endtask : load
endmodule : psr_rf_model

// file: sim/psr_unit_sva.sv
// concurrent checks on the ports of the packed simd and reverse unit
`timescale 1ns/1ps
`include "psr_map.svh"

module psr_unit_sva (
    input wire logic                      REF_CLK,
    input wire logic                      RST_B,
    input wire psr_pkg::psr_issue_t       ISSUE,
    input wire logic                      WR_EN,
    input wire logic [`PSR_REG_IDX_W-1:0] WR_IDX,
    input wire logic [`PSR_WORD_W-1:0]    WR_DATA,
    input wire logic [`PSR_FLAGS_W-1:0]   FLAGS_OUT,
    input wire logic                      ILLEGAL_REG
);
    import psr_pkg::*;
    logic [31:0] swap_w;
    logic [31:0] bit_reverse_word_w;

    // ==========================================================
    // reversed operand images, so checks stay one line each
    always_comb begin
        swap_w = {ISSUE.first_operand[7:0], ISSUE.first_operand[15:8],
                  ISSUE.first_operand[23:16], ISSUE.first_operand[31:24]};
        for (int k = 0; k < 32; k++) bit_reverse_word_w[k] = ISSUE.first_operand[31-k];
    end

    default clocking cb @(posedge REF_CLK); endclocking
    default disable iff (!RST_B);
    sequence issued_s; ISSUE.valid; endsequence
    sequence passed_s; ISSUE.valid && ISSUE.cond_pass; endsequence

    // ==========================================================
    // write strobe, flags, data and index
    write_on_pass_a: assert property (passed_s |=> WR_EN)
        else $error("write missing after passing op");
    write_block_a: assert property (!(ISSUE.valid && ISSUE.cond_pass) |=> !WR_EN)
        else $error("write without passing op");
    flags_keep_a: assert property (issued_s |=> FLAGS_OUT == $past(ISSUE.flags_in))
        else $error("flags altered by op");
    flags_hold_a: assert property (!ISSUE.valid |=> $stable(FLAGS_OUT))
        else $error("flags moved while idle");
    move_top_a: assert property (issued_s ##0 ISSUE.op == PSR_OP_MOVE_TOP_IMMEDIATE
        |=> WR_DATA == {$past(ISSUE.immediate_16), $past(ISSUE.dest_prior[15:0])}) else $error("move top wrong");
    byte_rev_a: assert property (issued_s ##0 ISSUE.op == PSR_OP_BYTE_REVERSE_WORD
        |=> WR_DATA == $past(swap_w)) else $error("word byte reverse wrong");
    bit_rev_a: assert property (issued_s ##0 ISSUE.op == PSR_OP_BIT_REVERSE_WORD
        |=> WR_DATA == $past(bit_reverse_word_w)) else $error("bit reverse wrong");
    dest_omit_a: assert property (issued_s ##0 (ISSUE.op >= PSR_OP_SIGNED_ADD_HALVES && !ISSUE.dest_given)
        |=> WR_IDX == $past(ISSUE.first_idx)) else $error("omitted destination index wrong");
endmodule : psr_unit_sva

bind psr_unit psr_unit_sva i_sva (.REF_CLK(REF_CLK), .RST_B(RST_B), .ISSUE(ISSUE), .WR_EN(WR_EN),
    .WR_IDX(WR_IDX), .WR_DATA(WR_DATA), .FLAGS_OUT(FLAGS_OUT), .ILLEGAL_REG(ILLEGAL_REG));

// file: sim/psr_unit_tb.sv
// self-checking bench for the packed simd and reverse unit
`timescale 1ns/1ps
`include "psr_map.svh"
`define CK(x, y) begin n_tests++; if ((x) !== (y)) begin err_count++; $display("mismatch %0t %h/%h", $time, x, y); end end

module psr_unit_tb;
    import psr_pkg::*;
    logic        REF_CLK = 1'b0;
    logic        RST_B = 1'b0;
    psr_issue_t  ctl = '0;
    psr_issue_t  iss;
    logic [3:0]  bidx = 4'h0;
    logic        WR_EN, ILLEGAL_REG;
    logic [3:0]  WR_IDX, FLAGS_OUT;
    logic [31:0] WR_DATA, rf_a, rf_b, rf_p;
    int          err_count = 0;
    int          n_tests = 0;

    // ==========================================================
    // clock, and operands merged in from the register file model
    always #10 REF_CLK = ~REF_CLK;
    always_comb begin
        iss = ctl;
        iss.first_operand = rf_a;
        iss.second_operand = rf_b;
        iss.dest_prior = rf_p;
    end

    psr_unit i_dut (.REF_CLK(REF_CLK), .RST_B(RST_B), .ISSUE(iss), .WR_EN(WR_EN), .WR_IDX(WR_IDX),
        .WR_DATA(WR_DATA), .FLAGS_OUT(FLAGS_OUT), .ILLEGAL_REG(ILLEGAL_REG));
    psr_rf_model i_rf (.ref_clk(REF_CLK), .a_idx(ctl.first_idx), .b_idx(bidx), .p_idx(ctl.dest_idx),
        .wr_en(WR_EN), .wr_idx(WR_IDX), .wr_data(WR_DATA), .a(rf_a), .b(rf_b), .p(rf_p));

    // lane-wise expected result, sums kept 17 bits wide so halving loses nothing
    function automatic logic [31:0] ref_f(logic [3:0] o, logic [31:0] a, b, p);
        logic [31:0] r, bx;
        logic signed [16:0] x, y, s;
        bit by, sb;
        r = 32'h0;
        by = o inside {4'h6, 4'h8, 4'hC, 4'hE};
        bx = (o inside {4'h9, 4'hA}) ? {b[15:0], b[31:16]} : b;
        case (o)
            4'h0: r = {16'hF123, p[15:0]};
            4'h1: r = {a[7:0], a[15:8], a[23:16], a[31:24]};
            4'h2: r = {a[23:16], a[31:24], a[7:0], a[15:8]};
            4'h3: r = {{16{a[7]}}, a[7:0], a[15:8]};
            4'h4: for (int k = 0; k < 32; k++) r[k] = a[31-k];
            default: for (int k = 0; k < 32; k += (by ? 8 : 16)) begin
                x = by ? $signed(a[k+:8]) : $signed(a[k+:16]);
                y = by ? $signed(bx[k+:8]) : $signed(bx[k+:16]);
                sb = (o > 4'hA) || (o == 4'h9 && k == 0) || (o == 4'hA && k == 16);
                s = sb ? x - y : x + y;
                if (o inside {[4'h7:4'hC]}) s = s >>> 1;
                if (by) r[k+:8] = s[7:0];
                else r[k+:16] = s[15:0];
            end
        endcase
        return r;
    endfunction : ref_f

    // one op, judged one cycle later; indexes 13 and 15 never issued
    task automatic go(logic [3:0] o, d, n, m, logic c, g);
        logic [31:0] e;
        @(posedge REF_CLK);
        ctl <= '{valid: 1'b1, op: psr_op_t'(o), cond_pass: c, dest_given: g, dest_idx: d, first_idx: n,
                 immediate_16: 16'hF123, flags_in: o, default: '0};
        bidx <= m;
        #1 e = ref_f(o, i_rf.rf_q[n], i_rf.rf_q[m], i_rf.rf_q[d]);
        @(posedge REF_CLK);
        ctl.valid <= 1'b0;
        #1 `CK(WR_EN, c)
        `CK(WR_DATA, e)
        `CK(WR_IDX, (g || o < 5) ? d : n)
        `CK(FLAGS_OUT, o)
        `CK(ILLEGAL_REG, 1'b0)
    endtask : go

    task t_move_top;
        i_rf.load(3, 32'h1234_5678);
        go(0, 3, 0, 0, 1, 1);
    endtask : t_move_top

    task t_reverse;
        i_rf.load(7, 32'h8123_45F6);
        for (int k = 1; k < 5; k++) go(k, 3, 7, 0, 1, 0);
        i_rf.load(7, 32'h0000_807F);
        go(3, 3, 7, 0, 1, 1);
    endtask : t_reverse

    task t_packed;
        i_rf.load(1, 32'h7FFF_80FF);
        i_rf.load(2, 32'h0001_8001);
        go(5, 4, 1, 2, 1, 1);
        go(6, 4, 1, 2, 1, 1);
        go(13, 4, 1, 2, 1, 1);
        go(14, 4, 1, 2, 1, 1);
    endtask : t_packed

    task t_halving;
        i_rf.load(1, 32'h7FFF_8000);
        i_rf.load(2, 32'h7FFF_8001);
        for (int k = 7; k < 13; k++) go(k, 4, 1, 2, 1, 1);
    endtask : t_halving

    task t_omit;
        i_rf.load(1, 32'h0102_0304);
        i_rf.load(2, 32'h0101_0101);
        go(5, 9, 1, 2, 1, 0);
        @(posedge REF_CLK);
        #1 `CK(i_rf.rf_q[1], 32'h0203_0405)
    endtask : t_omit

    // failed condition first alone, then back to back with a passing op
    task t_cond;
        go(6, 4, 1, 2, 0, 1);
        @(posedge REF_CLK);
        ctl <= '{valid: 1'b1, op: PSR_OP_SIGNED_ADD_HALVES, dest_given: 1'b1, dest_idx: 4'h5, first_idx: 4'h1, default: '0};
        @(posedge REF_CLK);
        ctl.cond_pass <= 1'b1;
        #1 `CK(WR_EN, 1'b0)
        @(posedge REF_CLK);
        ctl.valid <= 1'b0;
        #1 `CK(WR_EN, 1'b1)
    endtask : t_cond

    // diagnostic only: a reserved destination is flagged for one cycle
    task t_illegal;
        @(posedge REF_CLK);
        ctl <= '{valid: 1'b1, op: PSR_OP_SIGNED_ADD_BYTES, cond_pass: 1'b1, dest_given: 1'b1, dest_idx: 4'hD,
                 first_idx: 4'h1, default: '0};
        @(posedge REF_CLK);
        ctl.valid <= 1'b0;
        #1 `CK(ILLEGAL_REG, 1'b1)
        @(posedge REF_CLK);
        #1 `CK(ILLEGAL_REG, 1'b0)
    endtask : t_illegal

    task summarize;
        $display("comparisons %0d mismatches %0d", n_tests, err_count);
        if (err_count == 0 && n_tests > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask : summarize

    // ==========================================================
    // main sequence
    initial begin
        repeat (10) @(posedge REF_CLK);
        RST_B <= 1'b1;
        t_move_top();
        t_reverse();
        t_packed();
        t_halving();
        t_omit();
        t_cond();
        t_illegal();
        summarize();
    end
endmodule : psr_unit_tb
